// ### smtr_regs.svh
/*
  register offsets, field positions, reset values and timing counts for the
  static memory mode/timing configuration block.
  assumes a plain word-addressed register port with byte offsets.
*/
`ifndef SMTR_REGS_SVH
`define SMTR_REGS_SVH

`define SMTR_ADDR_W          8
`define SMTR_OFS_DIRECT_CMD  8'h10
`define SMTR_OFS_SET_CYCLES  8'h14
`define SMTR_OFS_MODE_STAGE  8'h18
`define SMTR_OFS_CS_TIMING0  8'h00
`define SMTR_OFS_CS_MODE0    8'h40
// per-chip-select stride between readback words
`define SMTR_CS_STRIDE       8'h04
`define SMTR_NUM_CS          4

// mode staging fields
`define SMTR_ADV_BIT         11
`define SMTR_BL_HI           5
`define SMTR_BL_LO           3
`define SMTR_MW_HI           1
`define SMTR_MW_LO           0
// direct command fields
`define SMTR_CS_HI           25
`define SMTR_CS_LO           23
`define SMTR_CMD_HI          22
`define SMTR_CMD_LO          21
`define SMTR_CMD_UPDATE      2'h2
// timing fields
`define SMTR_TR_HI           19
`define SMTR_TR_LO           17
`define SMTR_WP_HI           13
`define SMTR_WP_LO           11
`define SMTR_CEOE_HI         10
`define SMTR_CEOE_LO         8
`define SMTR_WC_HI           7
`define SMTR_WC_LO           4
`define SMTR_RC_HI           3
`define SMTR_RC_LO           0
// reset values of the active sets
`define SMTR_TIMING_RST      20'h2b3cc
`define SMTR_MODE_RST        6'h21

`endif

// ### smtr_pkg.sv
/*
  types shared by the static memory mode/timing configuration block.
  assumes the constants header is included by the users.
*/
package smtr_pkg;
  typedef logic [19:0] smtr_timing_t;
  // mode set: adv, burst[2:0], width[1:0]
  typedef logic [5:0]  smtr_mode_t;
  typedef enum logic [1:0]
  {
    SMTR_BL_ONE  = 2'h1,
    SMTR_BL_FOUR = 2'h2
  } smtr_burst_t;
  typedef enum logic [2:0]
  {
    SMTR_IDLE  = 3'h1,
    SMTR_LOAD  = 3'h2,
    SMTR_DONE  = 3'h4
  } smtr_state_t;
endpackage

// ### smtr_cs_bank.sv
/*
  per-chip-select active configuration store.
  assumes load strobes come from the register block on the same clock.
*/
`timescale 1ns/10ps
`include "smtr_regs.svh"
module smtr_cs_bank
  import smtr_pkg::*;
(
  input  wire logic          clk,        // system clock
  input  wire logic          rst_n,      // async reset
  input  wire logic          load,       // update pulse
  input  wire logic [1:0]    sel,        // target chip select
  input  wire smtr_timing_t  timing_in,  // staged timing
  input  wire smtr_mode_t    mode_in,    // staged mode
  input  wire logic [1:0]    rd_sel,     // readback select
  output smtr_timing_t       timing_out, // active timing of rd_sel
  output smtr_mode_t         mode_out    // active mode of rd_sel
);
  smtr_timing_t timing_reg [`SMTR_NUM_CS];
  smtr_mode_t   mode_reg   [`SMTR_NUM_CS];

  // one active set per chip select, loaded only by the update pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `SMTR_NUM_CS; i++)
      begin
        timing_reg[i] <= `SMTR_TIMING_RST;
        mode_reg[i]   <= `SMTR_MODE_RST;
      end
    end
    else if (load)
    begin
      timing_reg[sel] <= timing_in;
      mode_reg[sel]   <= mode_in;
    end
  end

  assign timing_out = timing_reg[rd_sel];
  assign mode_out   = mode_reg[rd_sel];
endmodule // smtr_cs_bank

// ### smtr_static_mem_cfg.sv
/*
  register port of the static memory mode and timing configuration: staging
  registers, update command and per-chip-select readback.
  assumes a single-cycle strobe master on REF_CLK; read data one cycle later.
*/
// Function
// - address latch used when mode bit 11 set
// - read burst length from mode bits 5-3
// - data bus width from mode bits 1-0
// - staged values apply only on update command
// - command type 10 means update
// - select field names chip select 0-3
// - timings counted in half-rate controller clocks
// - turnaround readback in bits 19-17
// - write pulse 13-11, oe delay 10-8
// - write cycle readback in bits 7-4
// - read cycle readback in bits 3-0
`timescale 1ns/10ps
`include "smtr_regs.svh"
module smtr_static_mem_cfg
  import smtr_pkg::*;
(
  input  wire logic        REF_CLK,   // 40 MHz system clock
  input  wire logic        RSTN,      // async reset, active low
  input  wire logic [7:0]  ADDR,      // register byte address
  input  wire logic [31:0] WDATA,     // write data
  input  wire logic        WR,        // write strobe
  input  wire logic        RD,        // read strobe
  output logic      [31:0] RDATA,     // read data, cycle after RD
  output logic             MEMCTL_CLOCK, // controller clock, fsys/2
  output logic             ALE_USED,  // cs0 address latch enable in use
  output logic [2:0]       READ_BURST_LENGTH, // cs0 burst code
  output logic [1:0]       BUS_WIDTH_SELECT,  // cs0 width code
  output logic             UPDATE_DONE // pulse after an update load
);
  smtr_timing_t cycles_stage_reg;
  smtr_mode_t   mode_stage_reg;
  smtr_state_t  state_reg;
  logic [1:0]   cs_sel_reg;
  logic         load;
  logic [1:0]   rd_sel;
  smtr_timing_t timing_rd;
  smtr_mode_t   mode_rd;
  smtr_mode_t   mode_cs0;
  logic         cmd_ok;

  // half-rate controller clock; all timing codes count its periods
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      MEMCTL_CLOCK <= 1'b0;
    else
      MEMCTL_CLOCK <= ~MEMCTL_CLOCK;
  end

  // staging writes; bits above 19 and unused mode bits are dropped, timing bits 16-14 are kept
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cycles_stage_reg <= `SMTR_TIMING_RST;
      mode_stage_reg   <= `SMTR_MODE_RST;
    end
    else if (WR && ADDR == `SMTR_OFS_SET_CYCLES)
      cycles_stage_reg <= WDATA[19:0];
    else if (WR && ADDR == `SMTR_OFS_MODE_STAGE)
    begin
      mode_stage_reg <= {WDATA[`SMTR_ADV_BIT],
                         WDATA[`SMTR_BL_HI:`SMTR_BL_LO],
                         WDATA[`SMTR_MW_HI:`SMTR_MW_LO]};
    end
  end

  // prohibited command type or select codes are ignored outright
  assign cmd_ok = WR && ADDR == `SMTR_OFS_DIRECT_CMD
                  && WDATA[`SMTR_CMD_HI:`SMTR_CMD_LO] == `SMTR_CMD_UPDATE
                  && WDATA[`SMTR_CS_HI] == 1'b0;

  // update sequencer: capture select, load one cycle later, then report
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_reg  <= SMTR_IDLE;
      cs_sel_reg <= 2'h0;
    end
    else
    begin
      case (state_reg)
        SMTR_IDLE:
          if (cmd_ok)
          begin
            state_reg  <= SMTR_LOAD;
            cs_sel_reg <= WDATA[`SMTR_CS_LO+1:`SMTR_CS_LO];
          end
        SMTR_LOAD:
          state_reg <= SMTR_DONE;
        SMTR_DONE:
          state_reg <= SMTR_IDLE;
        default:
          state_reg <= SMTR_IDLE;
      endcase
    end
  end

  assign load        = (state_reg == SMTR_LOAD);
  assign UPDATE_DONE = (state_reg == SMTR_DONE);

  // readback select from address, bits 3-2 give the chip select
  assign rd_sel = ADDR[3:2];

  smtr_cs_bank u_bank
  (
    .clk        (REF_CLK),
    .rst_n      (RSTN),
    .load       (load),
    .sel        (cs_sel_reg),
    .timing_in  (cycles_stage_reg),
    .mode_in    (mode_stage_reg),
    .rd_sel     (rd_sel),
    .timing_out (timing_rd),
    .mode_out   (mode_rd)
  );

  // cs0 mode view for the bus engine, kept registered
  smtr_cs_bank u_bank0
  (
    .clk        (REF_CLK),
    .rst_n      (RSTN),
    .load       (load && cs_sel_reg == 2'h0),
    .sel        (2'h0),
    .timing_in  (cycles_stage_reg),
    .mode_in    (mode_stage_reg),
    .rd_sel     (2'h0),
    .timing_out (),
    .mode_out   (mode_cs0)
  );

  // cs0 mode outputs drive the external waveform logic
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ALE_USED          <= 1'b1;
      READ_BURST_LENGTH <= 3'h0;
      BUS_WIDTH_SELECT  <= 2'h1;
    end
    else
    begin
      ALE_USED          <= mode_cs0[5];
      READ_BURST_LENGTH <= mode_cs0[4:2];
      BUS_WIDTH_SELECT  <= mode_cs0[1:0];
    end
  end

  // read mux; unused middle timing bits read zero, staging reads zero
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      RDATA <= 32'h0;
    // mode readback words, one per chip select
    else if (RD && ADDR[7:4] == 4'h4)
      RDATA <= {20'h0, mode_rd[5], 5'h0, mode_rd[4:2], 1'b0, mode_rd[1:0]};
    else if (RD && ADDR[7:4] == 4'h0 && ADDR[1:0] == 2'h0)
      RDATA <= {12'h0, timing_rd[`SMTR_TR_HI:`SMTR_TR_LO],
                3'h0,
                timing_rd[`SMTR_WP_HI:`SMTR_CEOE_LO],
                timing_rd[`SMTR_WC_HI:`SMTR_WC_LO],
                timing_rd[`SMTR_RC_HI:`SMTR_RC_LO]};
    else if (RD)
      RDATA <= 32'h0;
  end

  // assertions
  a_update_loads_stage:
    assert property (@(posedge REF_CLK) disable iff (!RSTN)
      cmd_ok && state_reg == SMTR_IDLE |=> load ##1 UPDATE_DONE)
    else $error("update command did not load");
  // watched on the bus itself, so a broken command decode still trips these
  a_bad_cmd_ignored:
    assert property (@(posedge REF_CLK) disable iff (!RSTN)
      WR && ADDR == `SMTR_OFS_DIRECT_CMD && WDATA[`SMTR_CMD_HI:`SMTR_CMD_LO] != `SMTR_CMD_UPDATE |=> !load)
    else $error("load without update command");
  a_bad_sel_ignored:
    assert property (@(posedge REF_CLK) disable iff (!RSTN)
      WR && ADDR == `SMTR_OFS_DIRECT_CMD && WDATA[`SMTR_CS_HI] |=> !load)
    else $error("load from prohibited select");
  a_load_needs_cmd:
    assert property (@(posedge REF_CLK) disable iff (!RSTN)
      load |-> $past(WR) && $past(ADDR) == `SMTR_OFS_DIRECT_CMD)
    else $error("load with no command before it");
  a_ctl_clock_half:
    assert property (@(posedge REF_CLK) disable iff (!RSTN)
      MEMCTL_CLOCK |=> !MEMCTL_CLOCK ##1 MEMCTL_CLOCK)
    else $error("controller clock not half rate");
  a_cs0_ale_follow:
    assert property (@(posedge REF_CLK) disable iff (!RSTN)
      load && cs_sel_reg == 2'h0 |=> ##1 ALE_USED == $past(mode_stage_reg[5], 2))
    else $error("ale use not loaded");
  a_cs0_burst_follow:
    assert property (@(posedge REF_CLK) disable iff (!RSTN)
      load && cs_sel_reg == 2'h0 |=> ##1 READ_BURST_LENGTH == $past(mode_stage_reg[4:2], 2))
    else $error("burst length not loaded");
  a_cs0_width_follow:
    assert property (@(posedge REF_CLK) disable iff (!RSTN)
      load && cs_sel_reg == 2'h0 |=> ##1 BUS_WIDTH_SELECT == $past(mode_stage_reg[1:0], 2))
    else $error("bus width not loaded");
  a_timing_readback:
    assert property (@(posedge REF_CLK) disable iff (!RSTN)
      RD && ADDR == `SMTR_OFS_CS_TIMING0 |=> RDATA[19:17] == $past(timing_rd[19:17]))
    else $error("turnaround readback wrong");
  a_timing_low_bits:
    assert property (@(posedge REF_CLK) disable iff (!RSTN)
      RD && ADDR == `SMTR_OFS_CS_TIMING0 |=> RDATA[13:0] == $past(timing_rd[13:0]))
    else $error("timing readback wrong");
  // every chip select word, not only cs0; middle bits are defined as zero here
  a_cs_timing_all:
    assert property (@(posedge REF_CLK) disable iff (!RSTN)
      RD && ADDR[7:4] == 4'h0 && ADDR[1:0] == 2'h0 |=> RDATA[19:17] == $past(timing_rd[19:17])
        && RDATA[16:14] == 3'h0 && RDATA[13:0] == $past(timing_rd[13:0]))
    else $error("chip select timing readback wrong");
  a_mode_readback:
    assert property (@(posedge REF_CLK) disable iff (!RSTN)
      RD && ADDR[7:4] == 4'h4 |=> RDATA[11] == $past(mode_rd[5]) && RDATA[5:3] == $past(mode_rd[4:2])
        && RDATA[1:0] == $past(mode_rd[1:0]))
    else $error("mode readback wrong");
endmodule // smtr_static_mem_cfg

// ### smtr_mem_model.sv
/*
  far-side stand-in for the static memory: follows the controller clock and bus mode.
  assumes it shares reset with the configuration block.
*/
`timescale 1ns/10ps
module smtr_mem_model
(
  input  wire logic       ref_clk,   // system clock
  input  wire logic       rst_n,     // async reset
  input  wire logic       mem_clk,   // controller clock
  input  wire logic       ale_used,  // multiplexed bus in use
  input  wire logic [1:0] width_sel, // data bus width code
  output logic [15:0]     mem_edges, // controller clock rising edges seen
  output logic            mode_ok    // mode this memory supports
);
  logic mem_clk_reg; // last sampled controller clock

  // memory runs on the half-rate clock, so count its rising edges
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_clk_reg <= 1'b0;
      mem_edges   <= 16'h0;
    end
    else
    begin
      mem_clk_reg <= mem_clk;
      if (mem_clk && !mem_clk_reg)
        mem_edges <= mem_edges + 16'h1;
    end
  end

  // only a multiplexed 16-bit bus is wired on this board
  assign mode_ok = ale_used && (width_sel == 2'h1);
endmodule // smtr_mem_model

// ### test_static_mem_mode_timing_regs.sv
/*
  self-checking bench for the static memory mode and timing configuration.
  assumes single-cycle strobes and read data one cycle after the read strobe.
*/
`timescale 1ns/10ps
`include "smtr_regs.svh"
module test_static_mem_mode_timing_regs;
  logic        ref_clk;
  logic        rstn;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        mem_clk;
  logic        ale;
  logic [2:0]  burst;
  logic [1:0]  width;
  logic        done;
  logic [15:0] mem_edges;
  logic        mode_ok;
  logic [15:0] e0;
  logic [31:0] modes [2];
  int          failures;
  int          num_checks;
  int          i;
  // reset timing set as read back: bits 16-14 read zero
  localparam logic [31:0] timing_rst_rb = 32'h000233cc;

  smtr_static_mem_cfg dut (.REF_CLK(ref_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .MEMCTL_CLOCK(mem_clk), .ALE_USED(ale), .READ_BURST_LENGTH(burst),
    .BUS_WIDTH_SELECT(width), .UPDATE_DONE(done));
  smtr_mem_model mem (.ref_clk(ref_clk), .rst_n(rstn), .mem_clk(mem_clk), .ale_used(ale),
    .width_sel(width), .mem_edges(mem_edges), .mode_ok(mode_ok));

  // 40 MHz system clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  // data appears in the cycle after the strobe and holds until the next read, so sample there
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // refused commands give no pulse; accepted ones get six cycles to finish
  task automatic update(input logic [2:0] cs, input logic [1:0] ty, input logic exp);
    logic seen;
    seen = 1'b0;
    wr_reg(`SMTR_OFS_DIRECT_CMD, {6'h0, cs, ty, 21'h0});
    repeat (6)
    begin
      @(posedge ref_clk);
      #1;
      if (done === 1'b1)
        seen = 1'b1;
    end
    chk({31'h0, seen}, {31'h0, exp});
    if (exp && seen !== 1'b1)
      test_done;
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    rstn = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    failures = 0;
    num_checks = 0;
    modes[0] = 32'h809;
    modes[1] = 32'h801;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    // every chip select starts from the same active set
    for (i = 0; i < 4; i++)
    begin
      rd_reg(8'(4 * i), timing_rst_rb);
      rd_reg(8'(8'h40 + 4 * i), 32'h801);
    end
    chk({26'h0, ale, burst, width}, {26'h0, 1'b1, 3'h0, 2'h1});
    $display("reset values done");
    // staged values stay invisible until a valid command; unused bits written zero
    wr_reg(`SMTR_OFS_MODE_STAGE, 32'h809);
    wr_reg(`SMTR_OFS_SET_CYCLES, 32'he3fff);
    rd_reg(`SMTR_OFS_MODE_STAGE, 32'h0);
    rd_reg(8'h04, timing_rst_rb);
    update(3'h1, 2'h1, 1'b0);
    update(3'h4, 2'h2, 1'b0);
    rd_reg(8'h04, timing_rst_rb);
    update(3'h1, 2'h2, 1'b1);
    rd_reg(8'h04, 32'he3fff);
    rd_reg(8'h44, 32'h809);
    rd_reg(8'h00, timing_rst_rb);
    rd_reg(8'h08, timing_rst_rb);
    // highest legal select reaches the last chip select
    update(3'h3, 2'h2, 1'b1);
    rd_reg(8'h0c, 32'he3fff);
    rd_reg(8'h4c, 32'h809);
    rd_reg(8'h08, timing_rst_rb);
    $display("staging and select done");
    // burst codes 1 and 0 through chip select 0
    for (i = 0; i < 2; i++)
    begin
      wr_reg(`SMTR_OFS_MODE_STAGE, modes[i]);
      update(3'h0, 2'h2, 1'b1);
      chk({31'h0, ale}, 32'h1);
      chk({29'h0, burst}, {29'h0, modes[i][5:3]});
      chk({30'h0, width}, 32'h1);
      chk({31'h0, mode_ok}, 32'h1);
    end
    rd_reg(8'h00, 32'he3fff);
    $display("mode outputs done");
    // readback is read-only; unmapped space reads zero
    wr_reg(8'h04, 32'h0);
    rd_reg(8'h04, 32'he3fff);
    rd_reg(8'h80, 32'h0);
    // controller clock runs at half the system rate
    @(posedge ref_clk);
    #1;
    e0 = mem_edges;
    repeat (20) @(posedge ref_clk);
    #1;
    chk({16'h0, mem_edges - e0}, 32'd10);
    $display("access and clock done");
    test_done;
  end

  // hard stop in case a task never returns
  initial
  begin
    #1000000;
    failures++;
    test_done;
  end
endmodule // test_static_mem_mode_timing_regs
